// >>> verilog/spps_pkg.sv
package spps_pkg;
	// Register word offsets (byte addresses)
	localparam logic [7:0] SPPS_OFF_DATA = 8'h00;
	localparam logic [7:0] SPPS_OFF_DIR = 8'h04;
	localparam logic [7:0] SPPS_OFF_PDI = 8'h08;
	localparam logic [7:0] SPPS_OFF_CTRL = 8'h0C;
	localparam logic [7:0] SPPS_OFF_STAT = 8'h10;
	// Pin indices within the 3-bit fields
	localparam int SPPS_PIN_SDO = 0;
	localparam int SPPS_PIN_SDI = 1;
	localparam int SPPS_PIN_SCK = 2;
	localparam int SPPS_NPINS = 3;
	// Control register bit positions
	localparam int SPPS_CTRL_SPE = 0;
	localparam int SPPS_CTRL_MASTER_SELECT = 1;
	// Status register bit positions
	localparam int SPPS_STAT_GPD = 0;
	localparam int SPPS_STAT_PIN = 1;
	// Reset values
	localparam logic [2:0] SPPS_DIR_RST = 3'h0;
	localparam logic [2:0] SPPS_PDI_RST = 3'h0;
	localparam logic [2:0] SPPS_DATA_RST = 3'h0;
	localparam logic [1:0] SPPS_CTRL_RST = 2'h0;
	localparam logic [31:0] SPPS_UNMAPPED = 32'h0000_0000;
	typedef enum logic [1:0] {
		SPPS_MODE_PORT_IN = 2'b00,
		SPPS_MODE_PORT_OUT = 2'b01,
		SPPS_MODE_SER_OUT = 2'b10,
		SPPS_MODE_SER_IN = 2'b11
	} spps_mode_t;
endpackage

// >>> verilog/spps_pin_cell.sv
`timescale 1ns/1ps
module spps_pin_cell
	import spps_pkg::*;
(
	input wire logic serial_own_i,
	input wire logic serial_drive_i,
	input wire logic serial_val_i,
	input wire logic dir_i,
	input wire logic latch_i,
	input wire logic inhibit_i,
	input wire logic global_pulldown_disable_i,
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	output logic pulldown_o,
	output logic rdback_o,
	output spps_mode_t mode_o
);
	always_comb begin
		if (serial_own_i) begin
			pin_oe_o = serial_drive_i;
			pin_o = serial_drive_i ? serial_val_i : 1'b0;
			pulldown_o = 1'b0;
			mode_o = serial_drive_i ? SPPS_MODE_SER_OUT : SPPS_MODE_SER_IN;
		end else begin
			pin_oe_o = dir_i;
			pin_o = dir_i ? latch_i : 1'b0;
			pulldown_o = !dir_i && !global_pulldown_disable_i && !inhibit_i;
			mode_o = dir_i ? SPPS_MODE_PORT_OUT : SPPS_MODE_PORT_IN;
		end
		rdback_o = dir_i ? latch_i : pin_i;
	end
endmodule // spps_pin_cell

// >>> verilog/spps_wb_slave.sv
`timescale 1ns/1ps
module spps_wb_slave
	import spps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	output logic ack_o,
	output logic wr_o,
	output logic rd_o
);
	logic ack_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= cyc_i && stb_i && !ack_r;
		end
	end
	assign ack_o = ack_r;
	assign wr_o = cyc_i && stb_i && we_i && !ack_r;
	assign rd_o = cyc_i && stb_i && !we_i && !ack_r;
endmodule // spps_wb_slave

// >>> verilog/spps_top.sv
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// What this block does
// - Serial on: data-out pin drives serial data
// - Serial on: data-in pin input to port
// - Master: clock pin drives port clock
// - Slave: clock pin input feeds port clock
// - Direction and latch stay accessible under serial
// - Readback: pin when input, latch when output
// - Serial off: stored port bits control pins
// - Pulldown on only when both disables clear
// - Plain output drives latch, pulldown off
// - Clock pin output always kills pulldown
// - Direction register always readable and writable
// - Latch writes accepted regardless of direction
// - Global disable kills pulldowns, survives reset
module spps_top
	import spps_pkg::*;
#(
	parameter int NPINS = SPPS_NPINS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic global_pulldown_disable_i,
	input wire logic serial_data_out_i,
	input wire logic serial_clock_out_i,
	output logic serial_data_in_o,
	output logic serial_clock_in_o,
	input wire logic [NPINS-1:0] pin_i,
	output logic [NPINS-1:0] pin_o,
	output logic [NPINS-1:0] pin_oe_o,
	output logic [NPINS-1:0] pulldown_o
);
	logic [NPINS-1:0] direction_r;
	logic [NPINS-1:0] latch_r;
	logic [NPINS-1:0] inhibit_r;
	logic serial_enable_r;
	logic master_select_r;
	logic [31:0] dat_r;
	logic wr;
	logic rd;
	logic [NPINS-1:0] rdback;
	logic [NPINS-1:0] drive;
	logic [NPINS-1:0] sval;
	spps_mode_t mode [NPINS];

	spps_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.ack_o(ack_o),
		.wr_o(wr),
		.rd_o(rd)
	);

	// Register writes, byte lane 0 only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			direction_r <= SPPS_DIR_RST;
		end else if (wr && sel_i[0] && adr_i == SPPS_OFF_DIR) begin
			direction_r <= dat_i[NPINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_r <= SPPS_DATA_RST;
		end else if (wr && sel_i[0] && adr_i == SPPS_OFF_DATA) begin
			latch_r <= dat_i[NPINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhibit_r <= SPPS_PDI_RST;
		end else if (wr && sel_i[0] && adr_i == SPPS_OFF_PDI) begin
			inhibit_r <= dat_i[NPINS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{master_select_r, serial_enable_r} <= SPPS_CTRL_RST;
		end else if (wr && sel_i[0] && adr_i == SPPS_OFF_CTRL) begin
			serial_enable_r <= dat_i[SPPS_CTRL_SPE];
			master_select_r <= dat_i[SPPS_CTRL_MASTER_SELECT];
		end
	end

	// Per-pin serial drive selection
	always_comb begin
		drive = '0;
		sval = '0;
		drive[SPPS_PIN_SDO] = 1'b1;
		sval[SPPS_PIN_SDO] = serial_data_out_i;
		drive[SPPS_PIN_SDI] = 1'b0;
		drive[SPPS_PIN_SCK] = master_select_r;
		sval[SPPS_PIN_SCK] = serial_clock_out_i;
	end

	for (genvar g = 0; g < NPINS; g++) begin : g_pin
		spps_pin_cell u_cell (
			.serial_own_i(serial_enable_r),
			.serial_drive_i(drive[g]),
			.serial_val_i(sval[g]),
			.dir_i(direction_r[g]),
			.latch_i(latch_r[g]),
			.inhibit_i(inhibit_r[g]),
			.global_pulldown_disable_i(global_pulldown_disable_i),
			.pin_i(pin_i[g]),
			.pin_o(pin_o[g]),
			.pin_oe_o(pin_oe_o[g]),
			.pulldown_o(pulldown_o[g]),
			.rdback_o(rdback[g]),
			.mode_o(mode[g])
		);
	end

	// Serial inputs from pins
	assign serial_data_in_o = serial_enable_r ? pin_i[SPPS_PIN_SDI] : 1'b0;
	assign serial_clock_in_o = (serial_enable_r && !master_select_r) ?
		pin_i[SPPS_PIN_SCK] : 1'b0;

	// Read data register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= SPPS_UNMAPPED;
		end else if (rd) begin
			if (adr_i == SPPS_OFF_DATA) begin
				dat_r <= 32'(rdback);
			end else if (adr_i == SPPS_OFF_DIR) begin
				dat_r <= 32'(direction_r);
			end else if (adr_i == SPPS_OFF_PDI) begin
				dat_r <= 32'(inhibit_r);
			end else if (adr_i == SPPS_OFF_CTRL) begin
				dat_r <= 32'({master_select_r, serial_enable_r});
			end else if (adr_i == SPPS_OFF_STAT) begin
				dat_r <= 32'({pulldown_o, global_pulldown_disable_i});
			end else begin
				dat_r <= SPPS_UNMAPPED;
			end
		end
	end
	assign dat_o = dat_r;
endmodule // spps_top

// >>> verification/spps_checker.sv
`timescale 1ns/1ps
module spps_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic global_pulldown_disable_i,
	input wire logic serial_data_out_i,
	input wire logic serial_clock_out_i,
	input wire logic serial_data_in_o,
	input wire logic serial_clock_in_o,
	input wire logic [2:0] pin_i,
	input wire logic [2:0] pin_o,
	input wire logic [2:0] pin_oe_o,
	input wire logic [2:0] pulldown_o
);
	logic [1:0] ctl_r;
	// Shadow of the control register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctl_r <= 2'h0;
		else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h0C)
			ctl_r <= dat_i[1:0];
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sdo_drive_a: assert property (ctl_r[0] |-> pin_oe_o[0] && !pulldown_o[0] &&
		pin_o[0] == serial_data_out_i) else $error("data-out pin wrong");
	sdi_route_a: assert property (ctl_r[0] |-> !pin_oe_o[1] && !pulldown_o[1] &&
		serial_data_in_o == pin_i[1]) else $error("data-in pin wrong");
	clk_master_a: assert property (ctl_r == 2'h3 |-> pin_oe_o[2] && !pulldown_o[2] &&
		pin_o[2] == serial_clock_out_i) else $error("master clock wrong");
	clk_slave_a: assert property (ctl_r == 2'h1 |-> !pin_oe_o[2] &&
		serial_clock_in_o == pin_i[2]) else $error("slave clock wrong");
	oe_pull_a: assert property ((pin_oe_o & pulldown_o) == 3'h0)
		else $error("pulldown on driven pin");
	gpd_off_a: assert property (global_pulldown_disable_i |-> pulldown_o == 3'h0)
		else $error("pulldown despite disable");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	ack_late_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
endmodule // spps_checker

// >>> verification/spps_ext_model.sv
`timescale 1ns/1ps
module spps_ext_model (
	input wire logic [2:0] val_i,
	input wire logic [2:0] oe_i,
	input wire logic [2:0] ext_i,
	output logic [2:0] lvl_o
);
	// Pin follows the driving side
	always_comb for (int k = 0; k < 3; k++) lvl_o[k] = oe_i[k] ? val_i[k] : ext_i[k];
endmodule // spps_ext_model

// >>> verification/serial_port_pin_sharing_tb.sv
`timescale 1ns/1ps
module serial_port_pin_sharing_tb;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, gpd = 0, serial_data_out = 0, sck = 0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic ack_o, serial_data_in, scki;
	logic [2:0] pin_i, pin_o, pin_oe_o, pulldown_o, ext = 3'h6;
	int num_errors = 0, cmp_count = 0, cyc_n = 0;
	spps_top DUT (.*, .global_pulldown_disable_i(gpd), .serial_data_out_i(serial_data_out),
		.serial_clock_out_i(sck), .serial_data_in_o(serial_data_in), .serial_clock_in_o(scki));
	spps_ext_model ext_dev (.val_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext), .lvl_o(pin_i));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic results();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 2000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hF, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		{cyc_i, stb_i, we_i} <= 3'h0;
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic drv(input logic [4:0] v);
		@(posedge clk_i);
		{serial_data_out, sck, ext} <= v;
		@(posedge clk_i);
	endtask
	task automatic t_port();
		chk("pd", 32'h7, pulldown_o);
		rdchk("data", 8'h00, 32'h6);
		rdchk("hole", 8'h20, 32'h0);
		wb(8'h08, 1'b1, 32'h5);
		chk("pd", 32'h2, pulldown_o);
		rdchk("pdi", 8'h08, 32'h5);
		rdchk("stat", 8'h10, 32'h4);
		gpd <= 1'b1;
		@(posedge clk_i);
		chk("pd", 32'h0, pulldown_o);
		gpd <= 1'b0;
		wb(8'h08, 1'b1, 32'h0);
		wb(8'h00, 1'b1, 32'h5);
		wb(8'h04, 1'b1, 32'h7);
		chk("oe", 32'h7, pin_oe_o);
		chk("pin", 32'h5, pin_o);
		rdchk("data", 8'h00, 32'h5);
	endtask
	task automatic t_serial();
		wb(8'h04, 1'b1, 32'h2);
		wb(8'h0C, 1'b1, 32'h3);
		rdchk("ctl", 8'h0C, 32'h3);
		drv(5'h1E);
		chk("oe", 32'h5, pin_oe_o);
		chk("pin", 32'h5, 32'(pin_o & 3'h5));
		chk("sdi", 32'h1, serial_data_in);
		rdchk("data", 8'h00, 32'h5);
		wb(8'h04, 1'b1, 32'h0);
		rdchk("dir", 8'h04, 32'h0);
		rdchk("data", 8'h00, 32'h7);
		wb(8'h0C, 1'b1, 32'h1);
		drv(5'h04);
		chk("oe", 32'h1, pin_oe_o);
		chk("sck", 32'h1, scki);
		wb(8'h04, 1'b1, 32'h6);
		wb(8'h0C, 1'b1, 32'h0);
		chk("oe", 32'h6, pin_oe_o);
		chk("pin", 32'h4, 32'(pin_o & 3'h6));
		chk("pd", 32'h1, pulldown_o);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_port();
		t_serial();
		results();
	end
endmodule // serial_port_pin_sharing_tb
bind spps_top spps_checker chk_i (.*);
